// file: sense_model.sv
`timescale 1ns/1ps
`default_nettype none
// analog side: comparators and sensors, changed just after each edge
module sense_model
   import supervisor_pkg::*;
(
   // clock
   input wire logic clock,
   // environment and regulator state
   input wire sense_s env,
   input wire logic short_main,
   input wire logic main_reg_on,
   // indications towards the supervisor
   output sense_s sense
);
   // main output is good only while enabled and not shorted, so a short
   // that outlives the shutdown still reads low after a restart
   always_ff @(posedge clock) begin
      sense <= env;
      sense.main_ok <= main_reg_on & ~short_main;
   end
endmodule
`default_nettype wire

// file: supervisor_pkg.sv
package supervisor_pkg;
   // clock rate and times, each in its own unit with the cycle count derived from it
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned SC_FILTER_US = 4000;
   localparam int unsigned SC_FILTER_CYC = SC_FILTER_US * CLK_MHZ;
   localparam int unsigned HOT_COOL_US = 1000000;
   localparam int unsigned HOT_COOL_CYC = HOT_COOL_US * CLK_MHZ;
   localparam int unsigned RESTART_US = 2000;
   localparam int unsigned RESTART_CYC = RESTART_US * CLK_MHZ;
   localparam int unsigned BLANK_US = 50;
   localparam int unsigned BLANK_CYC = BLANK_US * CLK_MHZ;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] FLAG_OFS = 8'h04;
   localparam logic [7:0] STATE_OFS = 8'h08;

   // control register fields
   localparam int C_MODE = 0;
   localparam int C_GO = 3;
   localparam int C_KEEP_LOW = 4;
   localparam int C_STOP_KEEP = 5;
   localparam int C_SHARE = 6;
   localparam int C_CAN_ON = 7;
   localparam int C_LIN_ON = 8;
   localparam int C_AUX_EN = 9;
   localparam int C_EXT_EN = 11;
   localparam int C_HS = 12;

   // flag register fields, write one to clear
   localparam int FLAG_W = 20;
   localparam int F_MSHORT = 0;
   localparam int F_FLAGA = 1;
   localparam int F_EXT_OC = 2;
   localparam int F_EXT_LOW = 3;
   localparam int F_AUX_LOW = 4;
   localparam int F_CAN_LOW = 5;
   localparam int F_STAGE = 6;
   localparam int F_AUX_OT = 7;
   localparam int F_EXT_OT = 8;
   localparam int F_WARM = 9;
   localparam int F_DEV_HOT = 10;
   localparam int F_HS = 12;
   localparam int F_CANF = 16;
   localparam int F_LINF = 18;
   localparam logic [1:0] FAULT_OT = 2'h1;

   // state register fields
   localparam int S_MAIN = 4;
   localparam int S_AUX = 5;
   localparam int S_EXT = 6;
   localparam int S_CANTX = 7;
   localparam int S_LINTX = 8;
   localparam int S_FAIL = 9;
   localparam int S_HS = 12;

   typedef enum logic [2:0] {
      M_NORMAL = 3'b000,
      M_STOP = 3'b001,
      M_SLEEP = 3'b010,
      M_RESTART = 3'b011,
      M_FAILSAFE = 3'b100
   } mode_e;

   // comparator and sensor indications, all active high
   typedef struct packed {
      logic main_ok;
      logic vs_ok;
      logic aux_low;
      logic can_low;
      logic ext_low;
      logic ext_oc;
      logic aux_ot;
      logic ext_ot;
      logic can_ot;
      logic lin_ot;
      logic [3:0] hs_ot;
      logic main_warm;
      logic main_hot;
      logic wake_can;
      logic wake_in;
   } sense_s;
endpackage

// file: supply_thermal_fault_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - main regulator not up within filter time after power-up or sleep: shut down, fail-safe
// - main regulator below threshold longer than filter time: same shutdown reaction
// - short detection only while battery supply is above undervoltage
// - short-circuit fail-safe is left only on CAN or wake-input wake
// - load sharing: regulator off on battery low or stop, per keep bits; no diagnostics
// - stand-alone: overcurrent and low flags; off on battery low unless keep bit
// - no short flag during main power-up, no ext low flag during ext turn-on
// - aux and CAN supply low set sticky flags cleared only by software
// - aux low flag not set while aux regulator turns on or off
// - stage overheat switches stage off, sets flag; clear only after cooling
// - per-stage thermal shutdown evaluated only for stages that are on
// - aux overheat: off, enable bits cleared, flag set; software re-enables
// - stand-alone ext overheat: off, enable cleared, flag set; software re-enables
// - load-sharing ext overheat: flag set, off, back on automatically after cooling
// - CAN overheat: transmitter off, receive only, fault field 01, auto recovery
// - LIN overheat: transmitter off, receive only, fault field 01, auto recovery
// - any high-side overheat: all switches off, control bits cleared, flags set
// - thermal flags never self-clear; software clears them after cooling
// - prewarning flag set while main on; clear only after overheat gone
// - second thermal level: fail-safe for cool-down, then restart, then normal
// - device thermal flag only while main on; clear in normal after cooling
module supply_thermal_fault_supervisor
   import supervisor_pkg::*;
#(
   parameter int unsigned SC_CYC = SC_FILTER_CYC,
   parameter int unsigned COOL_CYC = HOT_COOL_CYC,
   parameter int unsigned RST_CYC = RESTART_CYC,
   parameter int unsigned BLK_CYC = BLANK_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog indications
   input wire sense_s sense,
   // supply, transceiver and switch controls
   output logic main_reg_on,
   output logic aux_reg_on,
   output logic ext_reg_on,
   output logic can_tx_en,
   output logic lin_tx_en,
   output logic [3:0] high_side_switches,
   output logic fail_outputs,
   output mode_e mode
);

   sense_s s1_q, s_q;
   logic [FLAG_W-1:0] flags_q, set_v, allow_v;
   logic [31:0] sc_cnt_q, tm_q, aux_blk_q, ext_blk_q, rd_v;
   logic keep_low_q, stop_keep_q, share_q, can_on_q, lin_on_q, ext_en_q, sc_lock_q;
   logic [1:0] aux_en_q;
   logic [3:0] hs_en_q, hs_trip, hs_allow;
   logic wr_acc, wr_ctrl, wr_flag, go, sc_run, sc_hit, dev_hot_trip;
   logic aux_trip, ext_trip, can_trip, lin_trip, aux_on_d, ext_on_d;
   logic [1:0] go_mode;

   // two flops per indication; the first is seen only by the second
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s1_q <= '0;
         s_q <= '0;
      end else begin
         s1_q <= sense;
         s_q <= s1_q;
      end
   end

   // bus decode; writes land at the access edge with pready high
   assign wr_acc = psel & penable & pready & pwrite;
   assign wr_ctrl = wr_acc & (paddr == CTRL_OFS);
   assign wr_flag = wr_acc & (paddr == FLAG_OFS);
   assign go = wr_ctrl & pwdata[C_GO];
   assign go_mode = pwdata[C_MODE +: 2];

   // one wait-free access phase; read data is captured in the setup cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable & ~pready;
         if (psel & ~penable) begin
            prdata <= rd_v;
            pslverr <= ~((paddr == CTRL_OFS) | (paddr == FLAG_OFS) | (paddr == STATE_OFS));
         end
      end
   end

   // read multiplexer; unmapped offsets read zero with an error
   always_comb begin
      rd_v = 32'h0000_0000;
      case (paddr)
         CTRL_OFS: begin
            rd_v[C_KEEP_LOW] = keep_low_q;
            rd_v[C_STOP_KEEP] = stop_keep_q;
            rd_v[C_SHARE] = share_q;
            rd_v[C_CAN_ON] = can_on_q;
            rd_v[C_LIN_ON] = lin_on_q;
            rd_v[C_AUX_EN +: 2] = aux_en_q;
            rd_v[C_EXT_EN] = ext_en_q;
            rd_v[C_HS +: 4] = hs_en_q;
         end
         FLAG_OFS: rd_v[FLAG_W-1:0] = flags_q;
         STATE_OFS: begin
            rd_v[2:0] = mode;
            rd_v[S_MAIN] = main_reg_on;
            rd_v[S_AUX] = aux_reg_on;
            rd_v[S_EXT] = ext_reg_on;
            rd_v[S_CANTX] = can_tx_en;
            rd_v[S_LINTX] = lin_tx_en;
            rd_v[S_FAIL] = fail_outputs;
            rd_v[S_HS +: 4] = high_side_switches;
         end
         default: rd_v = 32'h0000_0000;
      endcase
   end

   // thermal trips only for stages that are switched on
   assign aux_trip = aux_reg_on & s_q.aux_ot;
   assign ext_trip = ext_reg_on & s_q.ext_ot;
   assign can_trip = can_on_q & s_q.can_ot;
   assign lin_trip = lin_on_q & s_q.lin_ot;
   assign dev_hot_trip = main_reg_on & s_q.main_hot & (mode != M_FAILSAFE);

   genvar i;
   for (i = 0; i < 4; i++) begin : g_hs
      assign hs_trip[i] = high_side_switches[i] & s_q.hs_ot[i];
      assign hs_allow[i] = ~s_q.hs_ot[i];
   end

   // short filter: counts only while on, battery fine and output low
   assign sc_run = main_reg_on & s_q.vs_ok & ~s_q.main_ok;
   assign sc_hit = sc_run & (sc_cnt_q == SC_CYC - 1);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sc_cnt_q <= 32'h0000_0000;
      end else if (!sc_run) begin
         sc_cnt_q <= 32'h0000_0000;
      end else if (sc_cnt_q != SC_CYC - 1) begin
         sc_cnt_q <= sc_cnt_q + 32'h0000_0001;
      end
   end

   // flag sources and the cooling gate on their clears
   always_comb begin
      set_v = '0;
      set_v[F_MSHORT] = sc_hit;
      set_v[F_FLAGA] = sc_hit;
      set_v[F_EXT_OC] = ~share_q & ext_reg_on & s_q.ext_oc;
      set_v[F_EXT_LOW] = ~share_q & ext_reg_on & (ext_blk_q == 0) & s_q.ext_low;
      set_v[F_AUX_LOW] = aux_reg_on & (aux_blk_q == 0) & s_q.aux_low;
      set_v[F_CAN_LOW] = s_q.can_low;
      set_v[F_STAGE] = aux_trip | can_trip | lin_trip | (|hs_trip);
      set_v[F_AUX_OT] = aux_trip;
      set_v[F_EXT_OT] = ext_trip;
      set_v[F_WARM] = main_reg_on & s_q.main_warm;
      set_v[F_DEV_HOT] = dev_hot_trip;
      set_v[F_HS +: 4] = {4{|hs_trip}} & s_q.hs_ot;
      set_v[F_CANF +: 2] = can_trip ? FAULT_OT : 2'h0;
      set_v[F_LINF +: 2] = lin_trip ? FAULT_OT : 2'h0;
      allow_v = '1;
      allow_v[F_STAGE] = ~(s_q.aux_ot | s_q.can_ot | s_q.lin_ot | (|s_q.hs_ot));
      allow_v[F_AUX_OT] = ~s_q.aux_ot;
      allow_v[F_EXT_OT] = ~s_q.ext_ot;
      allow_v[F_WARM] = ~s_q.main_warm;
      allow_v[F_DEV_HOT] = ~s_q.main_hot & (mode == M_NORMAL);
      allow_v[F_HS +: 4] = hs_allow;
      allow_v[F_CANF +: 2] = {2{~s_q.can_ot}};
      allow_v[F_LINF +: 2] = {2{~s_q.lin_ot}};
   end

   // sticky flags; a set in the clearing cycle wins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~({FLAG_W{wr_flag}} & pwdata[FLAG_W-1:0] & allow_v)) | set_v;
      end
   end

   // control bits; hardware clears on overheat win over software writes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         keep_low_q <= 1'b0;
         stop_keep_q <= 1'b0;
         share_q <= 1'b0;
         can_on_q <= 1'b0;
         lin_on_q <= 1'b0;
         aux_en_q <= 2'h0;
         ext_en_q <= 1'b0;
         hs_en_q <= 4'h0;
      end else begin
         if (wr_ctrl) begin
            keep_low_q <= pwdata[C_KEEP_LOW];
            stop_keep_q <= pwdata[C_STOP_KEEP];
            share_q <= pwdata[C_SHARE];
            can_on_q <= pwdata[C_CAN_ON];
            lin_on_q <= pwdata[C_LIN_ON];
            aux_en_q <= pwdata[C_AUX_EN +: 2];
            ext_en_q <= pwdata[C_EXT_EN];
            hs_en_q <= pwdata[C_HS +: 4];
         end
         if (aux_trip) begin
            aux_en_q <= 2'h0;
         end
         if (ext_trip & ~share_q) begin
            ext_en_q <= 1'b0;
         end
         if (|hs_trip) begin
            hs_en_q <= 4'h0;
         end
      end
   end

   // regulator enables; load sharing keeps its enable and retries after cooling
   assign aux_on_d = (|aux_en_q) & ~aux_trip;
   assign ext_on_d = ext_en_q & ~s_q.ext_ot & ~(~s_q.vs_ok & ~keep_low_q)
                     & ~(share_q & (mode == M_STOP) & ~stop_keep_q);

   // stage outputs plus blanking windows across aux switching edges and after ext turn-on
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         aux_reg_on <= 1'b0;
         ext_reg_on <= 1'b0;
         can_tx_en <= 1'b0;
         lin_tx_en <= 1'b0;
         high_side_switches <= 4'h0;
         aux_blk_q <= 32'h0000_0000;
         ext_blk_q <= 32'h0000_0000;
      end else begin
         aux_reg_on <= aux_on_d;
         ext_reg_on <= ext_on_d;
         can_tx_en <= can_on_q & ~s_q.can_ot;
         lin_tx_en <= lin_on_q & ~s_q.lin_ot;
         high_side_switches <= hs_en_q & ~{4{|hs_trip}};
         if (aux_on_d != aux_reg_on) begin
            aux_blk_q <= BLK_CYC;
         end else if (aux_blk_q != 0) begin
            aux_blk_q <= aux_blk_q - 32'h0000_0001;
         end
         if (ext_on_d & ~ext_reg_on) begin
            ext_blk_q <= BLK_CYC;
         end else if (ext_blk_q != 0) begin
            ext_blk_q <= ext_blk_q - 32'h0000_0001;
         end
      end
   end

   // operating mode; a short shutdown overrides everything else
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mode <= M_NORMAL;
         main_reg_on <= 1'b1;
         fail_outputs <= 1'b0;
         sc_lock_q <= 1'b0;
         tm_q <= 32'h0000_0000;
      end else if (sc_hit) begin
         mode <= M_FAILSAFE;
         main_reg_on <= 1'b0;
         fail_outputs <= 1'b1;
         sc_lock_q <= 1'b1;
      end else if (dev_hot_trip) begin
         mode <= M_FAILSAFE;
         tm_q <= COOL_CYC;
      end else begin
         case (mode)
            M_NORMAL: begin
               if (go & (go_mode == M_STOP[1:0])) begin
                  mode <= M_STOP;
               end else if (go & (go_mode == M_SLEEP[1:0])) begin
                  mode <= M_SLEEP;
                  main_reg_on <= 1'b0;
               end
            end
            M_STOP: begin
               if (go & (go_mode == M_NORMAL[1:0])) begin
                  mode <= M_NORMAL;
               end
            end
            M_SLEEP: begin
               // the filter restarts with the regulator, covering the wake ramp
               if (s_q.wake_can | s_q.wake_in) begin
                  mode <= M_RESTART;
                  main_reg_on <= 1'b1;
                  tm_q <= RST_CYC;
               end
            end
            M_RESTART: begin
               if (tm_q == 0) begin
                  mode <= M_NORMAL;
               end else begin
                  tm_q <= tm_q - 32'h0000_0001;
               end
            end
            M_FAILSAFE: begin
               if (sc_lock_q) begin
                  if (s_q.wake_can | s_q.wake_in) begin
                     mode <= M_RESTART;
                     main_reg_on <= 1'b1;
                     fail_outputs <= 1'b0;
                     sc_lock_q <= 1'b0;
                     tm_q <= RST_CYC;
                  end
               end else if (tm_q == 0) begin
                  mode <= M_RESTART;
                  tm_q <= RST_CYC;
               end else begin
                  tm_q <= tm_q - 32'h0000_0001;
               end
            end
            default: mode <= M_NORMAL;
         endcase
      end
   end

   a_sc_shutdown: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(flags_q[F_MSHORT]) |-> !main_reg_on && fail_outputs && flags_q[F_FLAGA]
      && mode == M_FAILSAFE) else $error("short did not shut down");
   a_sc_battery: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(flags_q[F_MSHORT]) |-> $past(s_q.vs_ok)) else $error("short with battery low");
   a_sc_wake_exit: assert property (@(posedge clock) disable iff (!rst_n)
      mode == M_FAILSAFE && sc_lock_q && !s_q.wake_can && !s_q.wake_in
      |=> mode == M_FAILSAFE) else $error("fail-safe left without wake");
   a_ls_stop_off: assert property (@(posedge clock) disable iff (!rst_n)
      share_q && mode == M_STOP && !stop_keep_q |=> !ext_reg_on)
      else $error("ext regulator on in stop");
   a_aux_overheat: assert property (@(posedge clock) disable iff (!rst_n)
      aux_trip |=> !aux_reg_on && aux_en_q == 2'h0 && flags_q[F_AUX_OT])
      else $error("aux overheat not handled");
   a_can_receive: assert property (@(posedge clock) disable iff (!rst_n)
      can_trip |=> !can_tx_en && flags_q[F_CANF +: 2] != 2'h0)
      else $error("can overheat not handled");
   a_hs_all_off: assert property (@(posedge clock) disable iff (!rst_n)
      |hs_trip |=> high_side_switches == 4'h0 && hs_en_q == 4'h0)
      else $error("high-side not all off");
   a_hot_cool: assert property (@(posedge clock) disable iff (!rst_n)
      dev_hot_trip && !sc_hit |=> mode == M_FAILSAFE && tm_q == COOL_CYC)
      else $error("no cool-down on device overheat");
   a_hot_clear: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(flags_q[F_DEV_HOT]) |-> $past(mode) == M_NORMAL && !$past(s_q.main_hot))
      else $error("device overheat flag cleared illegally");
   a_stage_hold: assert property (@(posedge clock) disable iff (!rst_n)
      flags_q[F_STAGE] && s_q.aux_ot |=> flags_q[F_STAGE])
      else $error("stage flag cleared while hot");
   a_apb_ready: assert property (@(posedge clock) disable iff (!rst_n)
      psel && !penable && !pready |=> pready ##1 !pready) else $error("pready timing");

endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import supervisor_pkg::*;
   localparam int SC = 20, CL = 30, RS = 10, BK = 5;
   localparam int STG = 1 << F_STAGE;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err, short_main;
   logic main_reg_on, aux_reg_on, ext_reg_on, can_tx_en, lin_tx_en, fail_outputs;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] high_side_switches;
   mode_e mode;
   sense_s env, sense;
   int num_errors = 0, total_checks = 0, exp_flags, b;
   int q[$];

   // shortened filter, cool-down, restart and blanking counts
   supply_thermal_fault_supervisor #(.SC_CYC(SC), .COOL_CYC(CL), .RST_CYC(RS),
      .BLK_CYC(BK)) dut_u (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
      .main_reg_on(main_reg_on), .aux_reg_on(aux_reg_on), .ext_reg_on(ext_reg_on),
      .can_tx_en(can_tx_en), .lin_tx_en(lin_tx_en),
      .high_side_switches(high_side_switches), .fail_outputs(fail_outputs),
      .mode(mode));
   sense_model pm_u (.clock(clock), .env(env), .short_main(short_main),
      .main_reg_on(main_reg_on), .sense(sense));

   // 200 MHz clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   // flag register against the model's sticky flag word
   task automatic flags(input string nm, input int mask = 32'hFFFFF);
      apb(1'b0, FLAG_OFS, 32'h0);
      chk(nm, rd & mask, exp_flags & mask);
   endtask

   task automatic clr(input int m);
      apb(1'b1, FLAG_OFS, m);
   endtask

   // expected mode sequence is popped from the queue, each under a bound
   task automatic modes(input int lim);
      int n;
      while (q.size() > 0) begin
         b = q.pop_front();
         for (n = 0; n < lim && mode !== mode_e'(b); n++) @(posedge clock);
         chk("mode_seq", mode, b);
         if (n >= lim) complete_run();
      end
   endtask

   // a hang ends the run through the same report
   initial begin
      tick(20000);
      num_errors++;
      complete_run();
   end

   initial begin
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      rst_n = 0;
      short_main = 0;
      env = '0;
      env.vs_ok = 1'b1;
      exp_flags = 0;
      void'($urandom(91800));
      tick(4);
      rst_n <= 1'b1;
      tick(3);
      chk("main_rst", main_reg_on, 1);
      chk("mode_rst", mode, M_NORMAL);
      chk("fail_rst", fail_outputs, 0);
      flags("flags_rst");
      apb(1'b1, 8'h0C, $urandom);
      chk("slverr_w", err, 1);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
      // low battery masks the short; a glitch below the filter is ignored
      env.vs_ok <= 1'b0;
      short_main <= 1'b1;
      tick(SC + 10);
      short_main <= 1'b0;
      env.vs_ok <= 1'b1;
      tick(6);
      flags("short_vs_low");
      short_main <= 1'b1;
      tick(SC - 5);
      short_main <= 1'b0;
      tick(6);
      flags("short_glitch");
      chk("main_glitch", main_reg_on, 1);
      // short shutdown, then wake by bus and by wake input
      for (int w = 0; w < 2; w++) begin
         short_main <= 1'b1;
         tick(SC + 8);
         exp_flags = (1 << F_MSHORT) | (1 << F_FLAGA);
         flags("short_flags");
         chk("short_off", {main_reg_on, fail_outputs}, 2'b01);
         short_main <= 1'b0;
         tick(20);
         chk("stay_fs", mode, M_FAILSAFE);
         if (w == 0) env.wake_can <= 1'b1;
         else env.wake_in <= 1'b1;
         tick(2);
         env.wake_can <= 1'b0;
         env.wake_in <= 1'b0;
         q = {M_RESTART, M_NORMAL};
         modes(RS + 10);
         chk("short_back", {main_reg_on, fail_outputs}, 2'b10);
         clr(exp_flags);
         exp_flags = 0;
         flags("short_clr");
      end
      // aux low hidden during turn-on, then sticky with can supply low
      apb(1'b1, CTRL_OFS, 32'h600);
      env.aux_low <= 1'b1;
      tick(1);
      env.aux_low <= 1'b0;
      tick(10);
      flags("aux_blank");
      env.aux_low <= 1'b1;
      env.can_low <= 1'b1;
      tick(3);
      env.aux_low <= 1'b0;
      env.can_low <= 1'b0;
      tick(6);
      exp_flags = (1 << F_AUX_LOW) | (1 << F_CAN_LOW);
      flags("low_sticky");
      clr(exp_flags);
      exp_flags = 0;
      flags("low_clr");
      // stages that are off ignore their overheat
      env.lin_ot <= 1'b1;
      env.hs_ot <= 4'hF;
      tick(6);
      flags("ot_off_stage");
      env.lin_ot <= 1'b0;
      env.hs_ot <= 4'h0;
      env.aux_ot <= 1'b1;
      tick(6);
      exp_flags = STG | (1 << F_AUX_OT);
      chk("aux_ot_off", aux_reg_on, 0);
      clr(exp_flags);
      flags("aux_ot_hot");
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("aux_en_bits", rd[10:9], 2'h0);
      env.aux_ot <= 1'b0;
      tick(6);
      flags("aux_ot_keep");
      clr(exp_flags);
      exp_flags = 0;
      flags("aux_ot_clr");
      // transmitters drop alone and come back by themselves
      apb(1'b1, CTRL_OFS, 32'hF180);
      for (int s = 0; s < 2; s++) begin
         if (s == 0) env.can_ot <= 1'b1;
         else env.lin_ot <= 1'b1;
         tick(6);
         chk("tx_off", {can_tx_en, lin_tx_en}, s == 0 ? 2'b01 : 2'b10);
         exp_flags = STG | (FAULT_OT << (s == 0 ? F_CANF : F_LINF));
         flags("tx_field");
         env.can_ot <= 1'b0;
         env.lin_ot <= 1'b0;
         tick(6);
         chk("tx_back", {can_tx_en, lin_tx_en}, 2'b11);
         clr(exp_flags);
         exp_flags = 0;
      end
      // one hot switch takes down all of them
      b = $urandom_range(3, 0);
      env.hs_ot[b] <= 1'b1;
      tick(6);
      chk("hs_all_off", high_side_switches, 0);
      apb(1'b0, FLAG_OFS, 32'h0);
      chk("hs_flag", {rd[F_HS + b], rd[F_STAGE]}, 2'b11);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("hs_ctrl", rd[15:12], 4'h0);
      env.hs_ot <= 4'h0;
      tick(6);
      clr(32'hFFFFF);
      flags("hs_clr");
      // stand-alone external regulator diagnostics
      apb(1'b1, CTRL_OFS, 32'h800);
      tick(BK + 5);
      env.ext_oc <= 1'b1;
      env.ext_low <= 1'b1;
      tick(3);
      env.ext_oc <= 1'b0;
      env.ext_low <= 1'b0;
      tick(6);
      exp_flags = (1 << F_EXT_OC) | (1 << F_EXT_LOW);
      flags("ext_diag");
      clr(exp_flags);
      exp_flags = 0;
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, CTRL_OFS, k == 0 ? 32'h800 : 32'h810);
         env.vs_ok <= 1'b0;
         tick(6);
         chk("ext_vs_low", ext_reg_on, k);
         env.vs_ok <= 1'b1;
         tick(6);
      end
      env.ext_ot <= 1'b1;
      tick(6);
      chk("ext_ot_off", ext_reg_on, 0);
      exp_flags = 1 << F_EXT_OT;
      flags("ext_ot_flag", ~STG);
      env.ext_ot <= 1'b0;
      tick(6);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ext_en_bit", {ext_reg_on, rd[11]}, 2'b00);
      clr(32'hFFFFF);
      exp_flags = 0;
      // load sharing: no diagnostics, auto restart after cooling
      apb(1'b1, CTRL_OFS, 32'h840);
      tick(BK + 5);
      env.ext_low <= 1'b1;
      env.ext_oc <= 1'b1;
      tick(6);
      flags("share_nodiag");
      env.ext_low <= 1'b0;
      env.ext_oc <= 1'b0;
      env.ext_ot <= 1'b1;
      tick(6);
      chk("share_ot_off", ext_reg_on, 0);
      exp_flags = 1 << F_EXT_OT;
      flags("share_ot_flag", ~STG);
      env.ext_ot <= 1'b0;
      tick(6);
      chk("share_ot_on", ext_reg_on, 1);
      clr(32'hFFFFF);
      exp_flags = 0;
      env.vs_ok <= 1'b0;
      tick(6);
      chk("share_vs_low", ext_reg_on, 0);
      env.vs_ok <= 1'b1;
      apb(1'b1, CTRL_OFS, 32'h849);
      tick(6);
      chk("share_stop", {mode, ext_reg_on}, {M_STOP, 1'b0});
      apb(1'b1, CTRL_OFS, 32'h848);
      tick(6);
      chk("share_norm", {mode, ext_reg_on}, {M_NORMAL, 1'b1});
      // prewarning holds while hot
      env.main_warm <= 1'b1;
      tick(6);
      exp_flags = 1 << F_WARM;
      clr(exp_flags);
      flags("warm_hot");
      env.main_warm <= 1'b0;
      tick(6);
      clr(exp_flags);
      exp_flags = 0;
      flags("warm_clr");
      // second level: fail-safe, cool-down, restart, normal
      env.main_hot <= 1'b1;
      tick(6);
      chk("hot_fs", {mode, fail_outputs}, {M_FAILSAFE, 1'b0});
      env.main_hot <= 1'b0;
      clr(1 << F_DEV_HOT);
      exp_flags = 1 << F_DEV_HOT;
      flags("hot_keep", 1 << F_DEV_HOT);
      q = {M_RESTART, M_NORMAL};
      modes(CL + RS + 20);
      clr(1 << F_DEV_HOT);
      exp_flags = 0;
      flags("hot_clr", 1 << F_DEV_HOT);
      // sleep drops the main regulator; a wake brings it back through restart
      apb(1'b1, CTRL_OFS, 32'h0000_000A);
      tick(6);
      chk("sleep", {mode, main_reg_on}, {M_SLEEP, 1'b0});
      env.wake_in <= 1'b1;
      tick(2);
      env.wake_in <= 1'b0;
      q = {M_RESTART, M_NORMAL};
      modes(RS + 10);
      chk("sleep_wake", {main_reg_on, fail_outputs}, 2'b10);
      flags("sleep_flags");
      complete_run();
   end
endmodule
`default_nettype wire
